// ---- design/aeb_pkg.sv ----
package aeb_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_OPERAND = 8'h04;
	localparam logic [7:0] REG_POINTER = 8'h08;
	localparam logic [7:0] REG_TARGET = 8'h0c;
	localparam logic [7:0] REG_FLAGS = 8'h10;
	localparam logic [7:0] REG_PC = 8'h14;
	localparam logic [7:0] REG_RESULT = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BIT_LSB = 6;
	localparam int CMD_TWO_BIT = 9;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Execution cycle counts
	// ------------------------------------------------------------
	localparam logic [2:0] CYC_ALU = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_JUMP = 3'h2;
	localparam logic [2:0] CYC_DIRECT_JUMP = 3'h3;
	localparam logic [2:0] CYC_CALL = 3'h3;
	localparam logic [2:0] CYC_DIRECT_CALL = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
	localparam logic [2:0] CYC_BRANCH = 3'h2;

	typedef enum logic [5:0] {
		op_add, op_add_carry, op_add_immediate_word, op_sub,
		op_subtract_with_borrow, op_subtract_immediate_word,
		op_and, op_or, op_exclusive_or_registers, op_set_mask_bits,
		op_clear_mask_bits, op_complement, op_negate, op_test,
		op_multiply, op_signed_multiply, op_mixed_sign_multiply,
		op_fractional_multiply, op_frac_signed_multiply,
		op_fractional_mixed_multiply, op_compare, op_compare_with_carry,
		op_compare_skip_equal, op_relative_jump, op_pointer_jump,
		op_direct_jump, op_relative_call, op_pointer_call,
		op_direct_call, op_return, op_interrupt_return,
		op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear,
		op_skip_io_bit_set, op_branch_flag_set, op_branch_flag_clear,
		op_branch_signed_ge, op_branch_signed_lt
	} aeb_op_e;

	typedef enum logic [1:0] {
		dest_none, dest_rd, dest_pair, dest_product
	} aeb_dest_e;

endpackage

// ---- design/aeb_alu.sv ----
`timescale 1ns/1ps
module aeb_alu (
	// Operation and operands
	input wire aeb_pkg::aeb_op_e op,
	input wire logic [7:0] rd_val,
	input wire logic [7:0] rr_val,
	input wire logic [15:0] word_val,
	input wire logic [15:0] imm_word,
	input wire logic [7:0] flags_in,
	// Result
	output logic [15:0] result,
	output logic [7:0] flags_out
);
	import aeb_pkg::*;

	typedef enum {fk_none, fk_add, fk_sub, fk_logic, fk_com, fk_neg,
		fk_word, fk_mul} aeb_fk_e;

	aeb_fk_e fk;
	logic [7:0] r8;
	logic [7:0] f;
	wire logic cin;
	wire logic keep_z;
	wire logic [8:0] sum9;
	wire logic [8:0] dif9;
	wire logic [7:0] neg8;
	wire logic [15:0] wres;
	wire logic a_sx;
	wire logic b_sx;
	wire logic frac;
	wire logic [15:0] prod;
	wire logic [15:0] mres;

	assign cin = (op == op_add_carry || op == op_subtract_with_borrow ||
		op == op_compare_with_carry) ? flags_in[FLAG_C] : 1'b0;
	assign keep_z = op == op_subtract_with_borrow ||
		op == op_compare_with_carry;
	assign sum9 = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, cin};
	assign dif9 = {1'b0, rd_val} - {1'b0, rr_val} - {8'h00, cin};
	assign neg8 = 8'h00 - rd_val;
	assign wres = (op == op_add_immediate_word) ? word_val + imm_word :
		word_val - imm_word;
	assign a_sx = op == op_signed_multiply || op == op_mixed_sign_multiply ||
		op == op_frac_signed_multiply || op == op_fractional_mixed_multiply;
	assign b_sx = op == op_signed_multiply || op == op_frac_signed_multiply;
	assign frac = op == op_fractional_multiply ||
		op == op_frac_signed_multiply || op == op_fractional_mixed_multiply;
	assign prod = {{8{a_sx & rd_val[7]}}, rd_val} *
		{{8{b_sx & rr_val[7]}}, rr_val};
	assign mres = frac ? {prod[14:0], 1'b0} : prod;

	// ------------------------------------------------------------
	// Byte result selection
	// ------------------------------------------------------------
	always_comb begin
		fk = fk_none;
		r8 = 8'h00;
		case (op)
		op_add, op_add_carry: begin
			r8 = sum9[7:0];
			fk = fk_add;
		end
		op_sub, op_subtract_with_borrow, op_compare,
		op_compare_with_carry: begin
			r8 = dif9[7:0];
			fk = fk_sub;
		end
		op_and: begin
			r8 = rd_val & rr_val;
			fk = fk_logic;
		end
		op_test: begin
			r8 = rd_val & rd_val;
			fk = fk_logic;
		end
		op_or, op_set_mask_bits: begin
			r8 = rd_val | rr_val;
			fk = fk_logic;
		end
		op_exclusive_or_registers: begin
			r8 = rd_val ^ rr_val;
			fk = fk_logic;
		end
		op_clear_mask_bits: begin
			r8 = rd_val & (8'hff - rr_val);
			fk = fk_logic;
		end
		op_complement: begin
			r8 = 8'hff - rd_val;
			fk = fk_com;
		end
		op_negate: begin
			r8 = neg8;
			fk = fk_neg;
		end
		op_add_immediate_word, op_subtract_immediate_word: fk = fk_word;
		op_multiply, op_signed_multiply, op_mixed_sign_multiply,
		op_fractional_multiply, op_frac_signed_multiply,
		op_fractional_mixed_multiply: fk = fk_mul;
		default: fk = fk_none;
		endcase
	end

	// ------------------------------------------------------------
	// Flag update per operation class
	// ------------------------------------------------------------
	always_comb begin
		f = flags_in;
		result = {8'h00, r8};
		case (fk)
		fk_add: begin
			f[FLAG_H] = (rd_val[3] & rr_val[3]) | (rr_val[3] & ~r8[3]) |
				(~r8[3] & rd_val[3]);
			f[FLAG_V] = (rd_val[7] & rr_val[7] & ~r8[7]) |
				(~rd_val[7] & ~rr_val[7] & r8[7]);
			f[FLAG_C] = sum9[8];
		end
		fk_sub: begin
			f[FLAG_H] = (~rd_val[3] & rr_val[3]) | (rr_val[3] & r8[3]) |
				(r8[3] & ~rd_val[3]);
			f[FLAG_V] = (rd_val[7] & ~rr_val[7] & ~r8[7]) |
				(~rd_val[7] & rr_val[7] & r8[7]);
			f[FLAG_C] = dif9[8];
		end
		fk_logic: f[FLAG_V] = 1'b0;
		fk_com: begin
			f[FLAG_V] = 1'b0;
			f[FLAG_C] = 1'b1;
		end
		fk_neg: begin
			f[FLAG_H] = neg8[3] | rd_val[3];
			f[FLAG_V] = neg8 == 8'h80;
			f[FLAG_C] = neg8 != 8'h00;
		end
		fk_word: begin
			result = wres;
			f[FLAG_N] = wres[15];
			f[FLAG_Z] = wres == 16'h0000;
			if (op == op_add_immediate_word) begin
				f[FLAG_V] = ~word_val[15] & wres[15];
				f[FLAG_C] = ~wres[15] & word_val[15];
			end else begin
				f[FLAG_V] = word_val[15] & ~wres[15];
				f[FLAG_C] = wres[15] & ~word_val[15];
			end
			f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
		end
		fk_mul: begin
			result = mres;
			f[FLAG_C] = prod[15];
			f[FLAG_Z] = mres == 16'h0000;
		end
		default: f = flags_in;
		endcase
		if (fk != fk_none && fk != fk_word && fk != fk_mul) begin
			f[FLAG_N] = r8[7];
			f[FLAG_Z] = (r8 == 8'h00) & (~keep_z | flags_in[FLAG_Z]);
		end
		flags_out = f;
	end

endmodule

// ---- design/aeb_core.sv ----
// Summary of operation
// - Add two bytes, optional carry in, one cycle, Z C N V H.
// - Add or subtract immediate on word pair, two cycles, Z C N V S.
// - Subtract register or constant, one cycle, Z C N V H.
// - Subtract with borrow also takes carry away, one cycle.
// - AND, OR, XOR in one cycle; Z N V only, carry kept.
// - Set mask ORs constant; clear mask ANDs with 0xff minus mask.
// - Test ANDs value with itself, keeps it, sets Z N V.
// - Byte multiplies write 16-bit product to pair, two cycles, Z C.
// - Fractional multiplies shift product left once before storing.
// - Relative jump PC+k+1, pointer jump from Z: two cycles; direct three.
// - Relative and pointer calls three cycles, direct four, returns four.
// - Compare and skip if equal advances PC by 2 or 3.
// - Compares compute difference without storing, update five flags.
// - Skip on register bit clear or set, one to three cycles.
// - Skip on I/O register bit clear or set, one to three cycles.
// - Flag branches test chosen flag, target PC+k+1, one or two cycles.
// - Signed branches decide on N xor V being zero or one.
// - Unsigned branches follow carry clear or set.
// - Interrupt enable branches follow the I flag.
// - Named flag branches never alter any flag.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module aeb_core (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aeb_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core state
	output logic [7:0] status_flags_register,
	output logic [15:0] pc,
	output logic busy,
	// Write-back and stack
	output logic wb_valid,
	output aeb_pkg::aeb_dest_e wb_dest,
	output logic [15:0] wb_data,
	output logic push_valid,
	output logic [15:0] push_addr
);
	import aeb_pkg::*;

	typedef enum logic {st_idle, st_exec} aeb_state_e;

	aeb_state_e state_q;
	aeb_op_e op_q;
	aeb_dest_e wb_kind_q;
	logic [2:0] bit_q, cnt_q, last_cyc_q;
	logic [7:0] rd_q, rr_q, io_q, flags_q;
	logic [15:0] word_q, z_q, stack_q, k_q, pc_q, res_q, push_q;
	logic two_q, wb_valid_q, push_valid_q, err_q;
	logic [31:0] rdata_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire logic setup = psel & ~penable;
	wire logic hit_cmd = paddr == REG_CMD;
	wire logic hit_operand = paddr == REG_OPERAND;
	wire logic hit_pointer = paddr == REG_POINTER;
	wire logic hit_target = paddr == REG_TARGET;
	wire logic hit_flags = paddr == REG_FLAGS;
	wire logic hit_pc = paddr == REG_PC;
	wire logic hit_result = paddr == REG_RESULT;
	wire logic hit_status = paddr == REG_STATUS;
	wire logic writable = hit_cmd | hit_operand | hit_pointer |
		hit_target | hit_flags | hit_pc;
	wire logic mapped = writable | hit_result | hit_status;
	wire logic busy_w = state_q == st_exec;
	wire logic bad = ~mapped | (pwrite & (busy_w | ~writable));
	wire logic wr = psel & penable & pwrite & ~err_q;
	wire logic start = wr & hit_cmd;
	wire logic [31:0] rd_mux =
		hit_cmd ? {22'h0, two_q, bit_q, op_q} :
		hit_operand ? {word_q, rr_q, rd_q} :
		hit_pointer ? {stack_q, z_q} :
		hit_target ? {8'h00, io_q, k_q} :
		hit_flags ? {24'h000000, flags_q} :
		hit_pc ? {16'h0000, pc_q} :
		hit_result ? {push_q, res_q} :
		hit_status ? {26'h0, last_cyc_q, wb_kind_q, busy_w} :
		32'h00000000;

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	logic [15:0] alu_res;
	logic [7:0] alu_flags;
	aeb_alu u_alu (
		.op(op_q), .rd_val(rd_q), .rr_val(rr_q), .word_val(word_q),
		.imm_word(k_q), .flags_in(flags_q), .result(alu_res),
		.flags_out(alu_flags)
	);

	// ------------------------------------------------------------
	// Branch and skip decision
	// ------------------------------------------------------------
	wire logic nxv = flags_q[FLAG_N] ^ flags_q[FLAG_V];
	wire logic [15:0] rel_target = pc_q + k_q + 16'h0001;
	wire logic [15:0] skip_target = pc_q + (two_q ? 16'h0003 : 16'h0002);
	wire logic [15:0] next_seq = pc_q + 16'h0001;
	logic taken;
	logic [2:0] need;
	logic [15:0] pc_d, push_d;
	logic push_d_valid;
	aeb_dest_e dest_d;

	always_comb begin
		case (op_q)
		op_compare_skip_equal: taken = rd_q == rr_q;
		op_skip_reg_bit_clear: taken = ~rd_q[bit_q];
		op_skip_reg_bit_set: taken = rd_q[bit_q];
		op_skip_io_bit_clear: taken = ~io_q[bit_q];
		op_skip_io_bit_set: taken = io_q[bit_q];
		op_branch_flag_set: taken = flags_q[bit_q];
		op_branch_flag_clear: taken = ~flags_q[bit_q];
		op_branch_signed_ge: taken = ~nxv;
		op_branch_signed_lt: taken = nxv;
		default: taken = 1'b0;
		endcase
	end
	always_comb begin
		need = CYC_ALU;
		pc_d = next_seq;
		push_d = next_seq;
		push_d_valid = 1'b0;
		case (op_q)
		op_add_immediate_word, op_subtract_immediate_word:
			need = CYC_WORD;
		op_multiply, op_signed_multiply, op_mixed_sign_multiply,
		op_fractional_multiply, op_frac_signed_multiply,
		op_fractional_mixed_multiply: need = CYC_MUL;
		op_relative_jump: begin
			need = CYC_JUMP;
			pc_d = rel_target;
		end
		op_pointer_jump: begin
			need = CYC_JUMP;
			pc_d = z_q;
		end
		op_direct_jump: begin
			need = CYC_DIRECT_JUMP;
			pc_d = k_q;
		end
		op_relative_call, op_pointer_call: begin
			need = CYC_CALL;
			pc_d = (op_q == op_pointer_call) ? z_q : rel_target;
			push_d_valid = 1'b1;
		end
		op_direct_call: begin
			need = CYC_DIRECT_CALL;
			pc_d = k_q;
			push_d = pc_q + 16'h0002;
			push_d_valid = 1'b1;
		end
		op_return, op_interrupt_return: begin
			need = CYC_RETURN;
			pc_d = stack_q;
		end
		op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
		op_skip_io_bit_clear, op_skip_io_bit_set: begin
			if (taken) begin
				need = two_q ? CYC_SKIP_TWO : CYC_SKIP_ONE;
				pc_d = skip_target;
			end
		end
		op_branch_flag_set, op_branch_flag_clear, op_branch_signed_ge,
		op_branch_signed_lt: begin
			if (taken) begin
				need = CYC_BRANCH;
				pc_d = rel_target;
			end
		end
		default: need = CYC_ALU;
		endcase
	end

	// Compares and test leave the registers untouched
	always_comb begin
		case (op_q)
		op_add, op_add_carry, op_sub, op_subtract_with_borrow,
		op_and, op_or, op_exclusive_or_registers, op_set_mask_bits,
		op_clear_mask_bits, op_complement, op_negate: dest_d = dest_rd;
		op_add_immediate_word, op_subtract_immediate_word:
			dest_d = dest_pair;
		op_multiply, op_signed_multiply, op_mixed_sign_multiply,
		op_fractional_multiply, op_frac_signed_multiply,
		op_fractional_mixed_multiply: dest_d = dest_product;
		default: dest_d = dest_none;
		endcase
	end

	wire logic done = busy_w && cnt_q == need;
	wire logic [7:0] flags_d = (op_q == op_interrupt_return) ?
		(flags_q | 8'h80) : alu_flags;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= st_idle;
			cnt_q <= 3'h0;
		end else if (start) begin
			state_q <= st_exec;
			cnt_q <= 3'h1;
		end else if (done) begin
			state_q <= st_idle;
		end else if (busy_w) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			op_q <= op_add;
			bit_q <= 3'h0;
			two_q <= 1'b0;
		end else if (start) begin
			op_q <= aeb_op_e'(pwdata[CMD_OP_LSB +: 6]);
			bit_q <= pwdata[CMD_BIT_LSB +: 3];
			two_q <= pwdata[CMD_TWO_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_q <= 8'h00;
			rr_q <= 8'h00;
			word_q <= 16'h0000;
			z_q <= 16'h0000;
			stack_q <= 16'h0000;
			k_q <= 16'h0000;
			io_q <= 8'h00;
		end else if (wr) begin
			if (hit_operand)
				{word_q, rr_q, rd_q} <= pwdata;
			if (hit_pointer)
				{stack_q, z_q} <= pwdata;
			if (hit_target)
				{io_q, k_q} <= pwdata[23:0];
		end
	end

	// Flags and PC change only at commit or by an idle write
	always_ff @(posedge clock) begin
		if (rst) begin
			flags_q <= FLAGS_RESET;
			pc_q <= PC_RESET;
		end else if (done) begin
			flags_q <= flags_d;
			pc_q <= pc_d;
		end else if (wr) begin
			if (hit_flags)
				flags_q <= pwdata[7:0];
			if (hit_pc)
				pc_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			res_q <= 16'h0000;
			push_q <= 16'h0000;
			wb_valid_q <= 1'b0;
			wb_kind_q <= dest_none;
			push_valid_q <= 1'b0;
			last_cyc_q <= 3'h0;
		end else begin
			wb_valid_q <= done && dest_d != dest_none;
			push_valid_q <= done && push_d_valid;
			if (done) begin
				res_q <= alu_res;
				push_q <= push_d;
				wb_kind_q <= dest_d;
				last_cyc_q <= cnt_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else if (setup) begin
			rdata_q <= pwrite ? 32'h00000000 : rd_mux;
			err_q <= bad;
		end
	end

	assign prdata = rdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & err_q;
	assign status_flags_register = flags_q;
	assign pc = pc_q;
	assign busy = busy_w;
	assign wb_valid = wb_valid_q;
	assign wb_dest = wb_kind_q;
	assign wb_data = res_q;
	assign push_valid = push_valid_q;
	assign push_addr = push_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic is_mul = dest_d == dest_product;
	wire logic is_logic = op_q == op_and || op_q == op_or ||
		op_q == op_exclusive_or_registers;
	wire logic is_branch = op_q == op_branch_flag_set ||
		op_q == op_branch_flag_clear || op_q == op_branch_signed_ge ||
		op_q == op_branch_signed_lt;

	add_one_cycle_a: assert property (
		start && pwdata[5:0] == 6'h00 |=> done ##1 !busy && wb_valid)
		else $error("add did not finish in one cycle");
	word_two_cycle_a: assert property (
		$rose(busy_w) && (op_q == op_add_immediate_word ||
		op_q == op_subtract_immediate_word) |=> busy_w ##1 !busy_w)
		else $error("word add or subtract not two cycles");
	sub_borrow_a: assert property (
		done && op_q == op_sub |=> flags_q[0] == ($past(rd_q) < $past(rr_q)))
		else $error("subtract carry wrong");
	logic_carry_a: assert property (
		done && is_logic |=> flags_q[0] == $past(flags_q[0]) && !flags_q[3])
		else $error("logic op touched carry or left V set");
	mul_dest_a: assert property (
		done && is_mul |-> cnt_q == 3'h2 ##1 wb_valid && wb_dest == dest_product)
		else $error("multiply timing or destination wrong");
	relative_jump_pc_a: assert property (
		done && op_q == op_relative_jump |=> pc_q == $past(rel_target))
		else $error("relative jump target wrong");
	call_cycles_a: assert property (
		done && op_q == op_direct_call |-> cnt_q == 3'h4 ##1 push_valid)
		else $error("direct call timing or push wrong");
	skip_equal_a: assert property (
		done && op_q == op_compare_skip_equal && rd_q == rr_q
		|=> pc_q == $past(skip_target))
		else $error("equal skip target wrong");
	branch_time_a: assert property (
		$rose(busy_w) && op_q == op_branch_flag_set
		|=> busy_w == flags_q[bit_q])
		else $error("flag branch cycle count wrong");
	signed_ge_a: assert property (
		done && op_q == op_branch_signed_ge && !nxv
		|=> pc_q == $past(rel_target))
		else $error("signed branch not taken");
	branch_flags_a: assert property (
		done && is_branch |=> flags_q == $past(flags_q))
		else $error("branch altered flags");

	add_seen_c: cover property (done && op_q == op_add);
	mul_seen_c: cover property (done && is_mul);
	skip_two_c: cover property (done && taken && two_q && !is_branch);
	branch_taken_c: cover property (done && is_branch && taken);

endmodule

// ---- testbench/aeb_regfile_model.sv ----
`timescale 1ns/1ps
module aeb_regfile_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Write-back and stack from the core
	input wire logic wb_valid,
	input wire aeb_pkg::aeb_dest_e wb_dest,
	input wire logic [15:0] wb_data,
	input wire logic push_valid,
	input wire logic [15:0] push_addr,
	// Observed state
	output logic [15:0] last_data,
	output logic [15:0] last_push,
	output int wb_n
);
	import aeb_pkg::*;
	// ------------------------------------------------
	// Capture of write-backs and pushes
	// ------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			last_data <= 16'h0;
			last_push <= 16'h0;
			wb_n <= 0;
		end else begin
			if (wb_valid) begin
				wb_n <= wb_n + 1;
				last_data <= wb_data;
			end
			if (push_valid) begin
				last_push <= push_addr;
			end
		end
	end
endmodule

// ---- testbench/alu_and_branch_execution_tb.sv ----
`timescale 1ns/1ps
module alu_and_branch_execution_tb;
	import aeb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, busy, wb_valid, push_valid, ev;
	logic [7:0] status_flags_register, f;
	logic [15:0] pc, wb_data, push_addr, last_data, last_push;
	aeb_dest_e wb_dest;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int wb_n, n0;

	aeb_core u_aeb_core (.clock, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .status_flags_register, .pc,
		.busy, .wb_valid, .wb_dest, .wb_data, .push_valid, .push_addr);
	aeb_regfile_model u_aeb_regfile_model (.clock, .rst, .wb_valid,
		.wb_dest, .wb_data, .push_valid, .push_addr, .last_data,
		.last_push, .wb_n);

	always #4 clock = ~clock;

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task end_sim();
		if (bad_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task run(input logic [5:0] op, input logic [3:0] x,
		input logic [31:0] opnd, input logic [31:0] tgt, input logic [7:0] fl,
		input logic [15:0] res, input logic [7:0] efl,
		input logic [15:0] epc, input int cyc, input bit wb);
		n0 = wb_n;
		apb(1'b1, REG_OPERAND, opnd);
		apb(1'b1, REG_TARGET, tgt);
		apb(1'b1, REG_FLAGS, {24'h0, fl});
		apb(1'b1, REG_PC, 32'h10);
		apb(1'b1, REG_CMD, {22'h0, x, op});
		do begin
			@(posedge clock);
			#1;
		end while (busy !== 1'b0);
		chk(status_flags_register, efl);
		chk(pc, epc);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rv[5:3], cyc);
		if (wb) begin
			chk(wb_n, n0 + 1);
			chk(last_data, res);
			apb(1'b0, REG_RESULT, 32'h0);
			chk(rv[15:0], res);
		end else begin
			chk(wb_n, n0);
		end
	endtask

	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, REG_FLAGS, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, REG_PC, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(ev, 1'b1);
		apb(1'b1, REG_RESULT, 32'h5);
		chk(ev, 1'b1);
		apb(1'b1, REG_POINTER, 32'h0abc1234);
		run(op_add,0,16'h017f,0,0,16'h80,8'h2c,16'h11,1,1);
		run(op_add_carry,0,16'h00ff,0,8'h01,0,8'h23,16'h11,1,1);
		run(op_add_immediate_word,0,32'hffff0000,16'h1,8'h10,0,8'h03,
			16'h11,2,1);
		run(op_subtract_immediate_word,0,32'h80000000,16'h1,0,16'h7fff,
			8'h18,16'h11,2,1);
		run(op_sub,0,16'h0100,0,8'h10,16'hff,8'h35,16'h11,1,1);
		run(op_subtract_with_borrow,0,16'h0f10,0,8'h03,0,8'h22,
			16'h11,1,1);
		run(op_subtract_with_borrow,0,16'h0f10,0,8'h01,0,8'h20,
			16'h11,1,1);
		run(op_and,0,16'h0ff0,0,8'h0d,0,8'h03,16'h11,1,1);
		run(op_or,0,16'h0180,0,8'h0b,16'h81,8'h05,16'h11,1,1);
		run(op_exclusive_or_registers,0,16'haaaa,0,0,0,8'h02,
			16'h11,1,1);
		run(op_set_mask_bits,0,16'h8001,0,0,16'h81,8'h04,16'h11,1,1);
		run(op_clear_mask_bits,0,16'h0fff,0,0,16'hf0,8'h04,
			16'h11,1,1);
		run(op_negate,0,16'h0001,0,0,16'hff,8'h25,16'h11,1,1);
		run(op_complement,0,16'h000f,0,0,16'hf0,8'h05,
			16'h11,1,1);
		run(op_test,0,16'h0080,0,8'h08,0,8'h04,16'h11,1,0);
		run(op_multiply,0,16'hffff,0,0,16'hfe01,8'h01,16'h11,2,1);
		chk(wb_dest, dest_product);
		run(op_signed_multiply,0,16'hffff,0,8'h02,16'h1,0,16'h11,2,1);
		run(op_mixed_sign_multiply,0,16'h02ff,0,0,16'hfffe,8'h01,
			16'h11,2,1);
		run(op_fractional_multiply,0,16'hffff,0,0,16'hfc02,8'h01,
			16'h11,2,1);
		run(op_frac_signed_multiply,0,16'h40c0,0,0,16'he000,8'h01,
			16'h11,2,1);
		run(op_fractional_mixed_multiply,0,16'h8080,0,0,16'h8000,8'h01,
			16'h11,2,1);
		run(op_compare,0,16'h0100,0,0,0,8'h25,16'h11,1,0);
		run(op_compare_with_carry,0,16'h0001,0,8'h03,0,8'h02,
			16'h11,1,0);
		run(op_relative_jump,0,0,16'hfffe,0,0,0,16'h000f,2,0);
		run(op_pointer_jump,0,0,0,0,0,0,16'h1234,2,0);
		run(op_direct_jump,0,0,16'h2000,0,0,0,16'h2000,3,0);
		run(op_relative_call,0,0,16'h0010,0,0,0,16'h0021,3,0);
		chk(last_push, 16'h11);
		run(op_pointer_call,0,0,0,0,0,0,16'h1234,3,0);
		run(op_return,0,0,0,0,0,0,16'h0abc,4,0);
		run(op_interrupt_return,0,0,0,0,0,8'h80,16'h0abc,4,0);
		run(op_direct_call,0,0,16'h2000,0,0,0,16'h2000,4,0);
		apb(1'b1, REG_CMD, 32'(op_direct_call));
		apb(1'b1, REG_CMD, 32'(op_add));
		chk(ev, 1'b1);
		repeat (6) @(posedge clock);
		chk(pc, 16'h2000);
		chk(last_push, 16'h2002);
		run(op_compare_skip_equal,0,16'h1111,0,0,0,0,16'h12,2,0);
		run(op_compare_skip_equal,8,16'h1111,0,0,0,0,16'h13,3,0);
		run(op_compare_skip_equal,0,16'h1211,0,0,0,0,16'h11,1,0);
		run(op_skip_reg_bit_clear,3,16'h0808,0,0,0,0,16'h11,1,0);
		run(op_skip_reg_bit_set,3,16'h0808,0,0,0,0,16'h12,2,0);
		run(op_skip_io_bit_clear,4'hf,0,0,0,0,0,16'h13,3,0);
		run(op_skip_io_bit_set,7,0,32'h800000,0,0,0,16'h12,2,0);
		for (int b = 0; b < 8; b++) begin
			f = 8'h01 << b;
			run(op_branch_flag_set,4'(b),0,16'h5,f,0,f,16'h16,2,0);
			run(op_branch_flag_clear,4'(b),0,16'h5,~f,0,~f,16'h16,2,0);
			run(op_branch_flag_set,4'(b),0,16'h5,~f,0,~f,16'h11,1,0);
		end
		run(op_branch_signed_ge,0,0,16'h5,8'h0c,0,8'h0c,16'h16,2,0);
		run(op_branch_signed_lt,0,0,16'h5,8'h0c,0,8'h0c,16'h11,1,0);
		run(op_branch_signed_lt,0,0,16'h5,8'h04,0,8'h04,16'h16,2,0);
		run(op_branch_signed_ge,0,0,16'h5,8'h08,0,8'h08,16'h11,1,0);
		end_sim();
	end
endmodule
